// ---- common/sld_if.sv ----
// interface: the two wire serial link between host and driver
`timescale 1ns/10ps
interface sld_if;
   logic ser_data;   // serial segment data, host driven
   logic ser_clk;    // serial clock, host driven
   // host end drives both wires
   modport host_mp (output ser_data, output ser_clk);
   // driver end only listens
   modport dev_mp  (input  ser_data, input  ser_clk);
endinterface

// ---- common/sld_pkg.sv ----
// package: shared constants of the serial lcd segment driver link
package sld_pkg;
   // ************************************************************
   // frame format
   // ************************************************************
   localparam int          SLD_SEG_COUNT     = 33;             // segment bits per frame
   localparam int          SLD_FILLER_BITS   = 2;              // trailing filler bits
   localparam int          SLD_FRAME_BITS    = 36;             // start + segments + fillers
   localparam logic [5:0]  SLD_LAST_BIT      = 6'd35;          // index of the final frame clock
   localparam logic [32:0] SLD_SEG_RESET     = 33'h0_0000_0000; // latches after reset
   // ************************************************************
   // backplane generation
   // ************************************************************
   localparam int          SLD_BP_DIV_BITS   = 4;              // divide by 16
   localparam int          SLD_OSC_PERIOD    = 16;             // sys cycles per oscillator period
   // ************************************************************
   // host side timing and buffering
   // ************************************************************
   localparam logic [3:0]  SLD_SCLK_HALF     = 4'd2;           // sys cycles per half link clock
   localparam int          SLD_FIFO_DEPTH    = 32;             // words of segment data
endpackage

// ---- design/sld_driver.sv ----
// design: lcd segment driver end, shift chain, latches and backplane
// Operation
// - data arrives on serial data and clock only
// - host frame: start one, 33 bits, 2 fillers
// - load moment marked by the start bit reaching stage 35 of the chain
// - host pre-encodes characters into segment bits
// - transfer finished by 36th clock falling edge
// - on a load an output changes only when its bit differs
// - host gives two clocks after 34 bits
// - 36th rising edge loads 33 bits
// - 36th falling edge clears the shift chain
// - clear spares first stage master; frames back-to-back
// - bits 35 and 36 ignored, zero preferred
// - each bit drives one fixed segment output
// - backplane is oscillator divided by 16
// - external backplane must have 50% duty
// - grounded timing pin stops internal oscillator
// - latches hold pattern until next full frame
`timescale 1ns/10ps
module sld_driver
   import sld_pkg::*;
#(
   parameter int OSC_PERIOD = SLD_OSC_PERIOD   // sys cycles per oscillator period
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        rc_timing_pin,
   input  wire logic        backplane_source_input,
   output      logic [32:0] segment_drive,
   output      logic        backplane_drive_output,
   sld_if.dev_mp            link
);
   // ************************************************************
   // link domain: shift chain
   // ************************************************************
   logic [35:0] chain_reg;         // shift chain, newest bit at bit 0
   logic        clear_reg;         // clear request caught on falling edge
   logic [32:0] latch_reg;         // output latches, link domain
   logic        load_tgl_reg;      // toggles once per load

   // start bit sitting one stage from the top marks the 36th rising edge
   wire         frame_full = chain_reg[34];

   // rising edge: shift, load latches, apply pending clear
   always_ff @(posedge link.ser_clk or negedge arst_n) begin
      if (!arst_n) begin
         chain_reg    <= '0;
         latch_reg    <= SLD_SEG_RESET;
         load_tgl_reg <= 1'b0;
      end else begin
         if (clear_reg) begin
            // clear spares the bit now entering stage one
            chain_reg <= {35'h0_0000_0000, link.ser_data};
         end else begin
            chain_reg <= {chain_reg[34:0], link.ser_data};
         end
         if (frame_full && !clear_reg) begin
            // bits 33..1 are segments 32..0; first filler at bit 0 unused
            latch_reg    <= chain_reg[33:1];
            load_tgl_reg <= !load_tgl_reg;
         end
         // otherwise latches hold indefinitely
      end
   end

   // falling edge of the 36th clock raises the clear
   always_ff @(negedge link.ser_clk or negedge arst_n) begin
      if (!arst_n) begin
         clear_reg <= 1'b0;
      end else begin
         clear_reg <= chain_reg[35];
      end
   end

   // ************************************************************
   // sys domain: pin synchronisers
   // ************************************************************
   logic        rc_s1_reg;         // timing pin, first stage
   logic        rc_s2_reg;         // timing pin, settled
   logic        bpi_s1_reg;        // external backplane, first stage
   logic        bpi_s2_reg;        // external backplane, settled
   logic        tgl_s1_reg;        // load toggle, first stage
   logic        tgl_s2_reg;        // load toggle, settled
   logic        tgl_s3_reg;        // load toggle, delayed for edge

   // two flops for each level entering the sys domain
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rc_s1_reg  <= 1'b0;
         rc_s2_reg  <= 1'b0;
         bpi_s1_reg <= 1'b0;
         bpi_s2_reg <= 1'b0;
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
      end else begin
         rc_s1_reg  <= rc_timing_pin;
         rc_s2_reg  <= rc_s1_reg;
         bpi_s1_reg <= backplane_source_input;
         bpi_s2_reg <= bpi_s1_reg;
         tgl_s1_reg <= load_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   // ************************************************************
   // sys domain: latch copy
   // ************************************************************
   logic [32:0] seg_sys_reg;       // latches as seen by the sys domain
   wire         load_seen = tgl_s2_reg ^ tgl_s3_reg; // one pulse per load

   // latch_reg is stable for a whole frame after a load, far longer
   // than the three sys cycles the toggle needs to cross
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seg_sys_reg <= SLD_SEG_RESET;
      end else if (load_seen) begin
         seg_sys_reg <= latch_reg;
      end
   end

   // ************************************************************
   // sys domain: oscillator and backplane
   // ************************************************************
   localparam int OCW = $clog2(OSC_PERIOD + 1);
   localparam logic [OCW-1:0] OSC_LAST = OCW'(OSC_PERIOD - 1);
   logic [OCW-1:0]             osc_cnt_reg;  // oscillator period counter
   logic [SLD_BP_DIV_BITS-1:0] bp_div_reg;   // divide by 16 stage
   logic                       bp_reg;       // backplane drive flop
   logic [32:0]                seg_drv_reg;  // segment drive flops

   // grounded timing pin means external backplane and idle oscillator
   wire         osc_run  = rc_s2_reg;
   wire         osc_tick = osc_run && (osc_cnt_reg == OSC_LAST);
   // external source assumed balanced by the board
   wire         bp_src   = osc_run ? bp_div_reg[SLD_BP_DIV_BITS-1] : bpi_s2_reg;

   // internal oscillator, held at zero while disabled
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         osc_cnt_reg <= '0;
      end else if (!osc_run || osc_tick) begin
         osc_cnt_reg <= '0;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 1'b1;
      end
   end

   // msb of a 4 bit count of oscillator periods: period times 16
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bp_div_reg <= '0;
      end else if (osc_tick) begin
         bp_div_reg <= bp_div_reg + 1'b1;
      end
   end

   // output flops; set bits drive antiphase, clear bits in phase
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bp_reg      <= 1'b0;
         seg_drv_reg <= '0;
      end else begin
         bp_reg      <= bp_src;
         // a pin changes drive when its own bit changed or the backplane moves
         seg_drv_reg <= seg_sys_reg ^ {SLD_SEG_COUNT{bp_src}};
      end
   end

   // outputs straight from flops
   assign backplane_drive_output = bp_reg;
   assign segment_drive          = seg_drv_reg;
endmodule

// ---- design/sld_host.sv ----
// design: host end with input fifo and frame serialiser
`timescale 1ns/10ps
// ************************************************************
// fifo of segment words
// ************************************************************
module sld_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];      // storage array
   logic [AW:0]      wptr_reg;         // write pointer with wrap bit
   logic [AW:0]      rptr_reg;         // read pointer with wrap bit
   wire              empty = (wptr_reg == rptr_reg);
   wire              full  = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
   wire              push  = in_valid && !full;
   wire              pop   = out_ready && !empty;
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rptr_reg[AW-1:0]];
   // storage write, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wptr_reg[AW-1:0]] <= in_data;
      end
   end
   // pointer update
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
      end else begin
         if (push) wptr_reg <= wptr_reg + 1'b1;
         if (pop)  rptr_reg <= rptr_reg + 1'b1;
      end
   end
endmodule

// ************************************************************
// host serialiser
// ************************************************************
module sld_host
   import sld_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [32:0] seg_word,
   input  wire logic        seg_valid,
   output      logic        seg_ready,
   output      logic        busy,
   sld_if.host_mp           link
);
   typedef enum logic [1:0] {SLD_ST_IDLE = 2'b01, SLD_ST_SHIFT = 2'b10} sld_state_t;
   sld_state_t  state_reg;             // serialiser state
   logic [35:0] frame_reg;             // frame being sent, msb on the wire
   logic [5:0]  bit_reg;               // clock index within frame
   logic [3:0]  div_reg;               // half period divider
   logic        sclk_reg;              // link clock made by divider
   logic        busy_reg;              // frame in flight
   logic [32:0] fifo_data;             // head word
   logic        fifo_valid;            // head present
   wire         half_done  = (div_reg == SLD_SCLK_HALF - 4'd1);
   wire         frame_end  = (state_reg == SLD_ST_SHIFT) && half_done && sclk_reg && (bit_reg == SLD_LAST_BIT);
   wire         take_word  = fifo_valid && ((state_reg == SLD_ST_IDLE) || frame_end);
   // start bit, segments, zero fillers; host pre-formats shapes
   wire  [35:0] new_frame  = {1'b1, fifo_data, 2'b00};
   sld_fifo #(.WIDTH(SLD_SEG_COUNT), .DEPTH(SLD_FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_data   (seg_word),
      .in_valid  (seg_valid),
      .in_ready  (seg_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (take_word)
   );
   // two wires only: data and clock
   assign link.ser_data = frame_reg[35];
   assign link.ser_clk  = sclk_reg;
   assign busy          = busy_reg;
   // frame sequencer; data moves while clock is low
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SLD_ST_IDLE;
         frame_reg <= '0;
         bit_reg   <= '0;
         div_reg   <= '0;
         sclk_reg  <= 1'b0;
         busy_reg  <= 1'b0;
      end else begin
         unique case (state_reg)
            SLD_ST_IDLE: begin
               div_reg <= '0;
               if (take_word) begin
                  frame_reg <= new_frame;
                  bit_reg   <= '0;
                  state_reg <= SLD_ST_SHIFT;
                  busy_reg  <= 1'b1;
               end
            end
            SLD_ST_SHIFT: begin
               div_reg <= half_done ? 4'd0 : div_reg + 4'd1;
               if (half_done && !sclk_reg) begin
                  sclk_reg <= 1'b1;              // rising edge, driver samples
               end else if (half_done) begin
                  sclk_reg <= 1'b0;
                  if (bit_reg == SLD_LAST_BIT) begin
                     // 36 clocks done, two beyond the 34 defined bits
                     bit_reg <= '0;
                     if (take_word) begin
                        frame_reg <= new_frame;  // back to back frame
                     end else begin
                        frame_reg <= '0;
                        state_reg <= SLD_ST_IDLE;
                        busy_reg  <= 1'b0;
                     end
                  end else begin
                     bit_reg   <= bit_reg + 6'd1;
                     frame_reg <= {frame_reg[34:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end
endmodule

// ---- tb/serial_lcd_segment_driver_tb.sv ----
// testbench: host and driver ends on one link, a lone driver on a fault link
`timescale 1ns/10ps
module serial_lcd_segment_driver_tb
   import sld_pkg::*;
;
   localparam int OSC = 4;                // short oscillator period
   logic        clock = 1'b0;             // system clock
   logic        arst_n = 1'b0;            // async reset
   logic [32:0] seg_word = 33'h0;         // word offered to host
   logic        seg_valid = 1'b0;         // word valid
   logic        seg_ready;                // fifo has room
   logic        busy;                     // frame in flight
   logic        rc_timing_pin = 1'b0;     // oscillator enable
   logic        backplane_source_input = 1'b0;
   logic [32:0] segment_drive;            // main driver segments
   logic        backplane_drive_output;   // main backplane
   logic [32:0] seg_flt;                  // fault link segments
   logic [32:0] last;                     // expected pattern
   logic [32:0] q[$];                     // words to send
   logic        bp_q = 1'b0;
   logic        busy_q = 1'b0;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          bp_edges = 0;
   int          busy_falls = 0;
   int          n;
   always #25 clock = ~clock;
   sld_if i_sld_if ();
   sld_if i_sld_if_flt ();
   sld_host i_sld_host (.clock(clock), .arst_n(arst_n), .seg_word(seg_word), .seg_valid(seg_valid),
      .seg_ready(seg_ready), .busy(busy), .link(i_sld_if.host_mp));
   sld_driver #(.OSC_PERIOD(OSC)) i_sld_driver (.clock(clock), .arst_n(arst_n), .rc_timing_pin(rc_timing_pin),
      .backplane_source_input(backplane_source_input), .segment_drive(segment_drive),
      .backplane_drive_output(backplane_drive_output), .link(i_sld_if.dev_mp));
   sld_driver #(.OSC_PERIOD(OSC)) i_sld_driver_flt (.clock(clock), .arst_n(arst_n), .rc_timing_pin(1'b0),
      .backplane_source_input(1'b0), .segment_drive(seg_flt), .backplane_drive_output(),
      .link(i_sld_if_flt.dev_mp));
   sld_monitor i_sld_monitor (.clock(clock), .arst_n(arst_n), .ser_clk(i_sld_if.ser_clk),
      .ser_data(i_sld_if.ser_data), .busy(busy), .segment_drive(segment_drive),
      .backplane_drive_output(backplane_drive_output));
   // edge counters and timeout, on the falling edge to stay clear of stimulus
   always @(negedge clock) begin
      cycles++;
      bp_q   <= backplane_drive_output;
      busy_q <= busy;
      if (bp_q !== backplane_drive_output) bp_edges++;
      if (busy_q === 1'b1 && busy === 1'b0) busy_falls++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // offer words back to back, each held until taken
   task automatic send(input logic [32:0] w[$]);
      foreach (w[i]) begin
         seg_word  <= w[i];
         seg_valid <= 1'b1;
         // ready only moves on rising edges, so the falling edge shows what the next rise samples
         @(negedge clock);
         while (seg_ready !== 1'b1) @(negedge clock);
         @(posedge clock);
      end
      seg_valid <= 1'b0;
   endtask
   task automatic wait_idle();
      repeat (4) @(posedge clock);
      while (busy !== 1'b0) @(posedge clock);
      repeat (8) @(posedge clock);
   endtask
   // bench-made 15 ns link clock; data moves on falling edges
   task automatic raw_frame(input logic [35:0] bits);
      for (int i = 35; i >= 0; i--) begin
         i_sld_if_flt.ser_data = bits[i];
         #7.5 i_sld_if_flt.ser_clk = 1'b1;
         #7.5 i_sld_if_flt.ser_clk = 1'b0;
      end
      i_sld_if_flt.ser_data = ~bits[0];
   endtask
   initial begin
      i_sld_if_flt.ser_clk = 1'b0;
      i_sld_if_flt.ser_data = 1'b0;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      check("segments after reset", SLD_SEG_RESET, segment_drive);
      check("ready after reset", 33'h1, {32'h0, seg_ready});
      // boundary patterns one frame each, last one repeated
      q = {33'h1_0000_0001, 33'h0_aaaa_5555, 33'h1_ffff_ffff, 33'h1_ffff_ffff};
      foreach (q[i]) begin
         send({q[i]});
         wait_idle();
         check("segments after frame", q[i], segment_drive);
      end
      // three frames with no gap
      n = busy_falls;
      send({33'h0_1234_5678, 33'h1_8765_4321, 33'h0_0f0f_f0f0});
      wait_idle();
      check("busy drops in burst", 33'h1, 33'(busy_falls - n));
      check("segments after burst", 33'h0_0f0f_f0f0, segment_drive);
      // fill the fifo until refused, then drain
      seg_word  <= 33'h1_5a5a_a5a5;
      seg_valid <= 1'b1;
      n = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clock);
         if (seg_ready !== 1'b1) break;
         @(posedge clock);
         n++;
         seg_word <= 33'h1_5a5a_a5a5 ^ 33'(n);
      end
      // release on a rising edge; the refused word is not pushed there
      @(posedge clock);
      seg_valid <= 1'b0;
      check("words taken before refusal", 33'(SLD_FIFO_DEPTH + 1), 33'(n));
      last = 33'h1_5a5a_a5a5 ^ 33'(n - 1);
      wait_idle();
      check("segments after drain", last, segment_drive);
      // external backplane high inverts every segment
      backplane_source_input <= 1'b1;
      repeat (10) @(posedge clock);
      check("backplane follows input", 33'h1, {32'h0, backplane_drive_output});
      check("segments against backplane", ~last, segment_drive);
      backplane_source_input <= 1'b0;
      repeat (10) @(posedge clock);
      n = bp_edges;
      repeat (200) @(posedge clock);
      check("backplane still, pin grounded", 33'h0, 33'(bp_edges - n));
      // internal oscillator: eight edges in four backplane periods
      rc_timing_pin <= 1'b1;
      repeat (100) @(posedge clock);
      n = bp_edges;
      repeat (16 * OSC * 4) @(posedge clock);
      check("backplane edges", 33'h8, 33'(bp_edges - n));
      rc_timing_pin <= 1'b0;
      // fault link: set fillers, then a frame with no start bit
      raw_frame({1'b1, 33'h1_3c3c_c3c3, 2'b11});
      repeat (10) @(posedge clock);
      check("loads with set fillers", 33'h1_3c3c_c3c3, seg_flt);
      raw_frame({1'b0, 33'h0_0f0f_0f0f, 2'b00});
      repeat (10) @(posedge clock);
      check("no load without start", 33'h1_3c3c_c3c3, seg_flt);
      finish_test();
   end
endmodule

// ---- tb/sld_monitor.sv ----
// checker: link framing and latch timing between host and driver ends
`timescale 1ns/10ps
module sld_monitor
   import sld_pkg::*;
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        ser_clk,
   input wire logic        ser_data,
   input wire logic        busy,
   input wire logic [32:0] segment_drive,
   input wire logic        backplane_drive_output
);
   // ************************************************************
   // helper state
   // ************************************************************
   logic        clk_q_reg;     // link clock one cycle ago
   logic [5:0]  rise_reg;      // link rises so far in the frame
   logic [32:0] shadow_reg;    // segment bits seen on the wire
   logic [3:0]  quiet_reg;     // cycles since load or backplane edge
   logic        bp_q_reg;      // backplane one cycle ago
   wire         rise_w = ser_clk & ~clk_q_reg;
   wire         load_w = rise_w & (rise_reg == SLD_LAST_BIT);
   // count rises, keep data bits 1..33, time the quiet spans
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clk_q_reg  <= 1'b0;
         rise_reg   <= 6'h0;
         shadow_reg <= 33'h0;
         quiet_reg  <= 4'h0;
         bp_q_reg   <= 1'b0;
      end else begin
         clk_q_reg <= ser_clk;
         bp_q_reg  <= backplane_drive_output;
         if (!busy) rise_reg <= 6'h0;
         else if (rise_w) rise_reg <= load_w ? 6'h0 : rise_reg + 6'h1;
         if (rise_w && rise_reg != 6'h0 && rise_reg < 6'h22) shadow_reg <= {shadow_reg[31:0], ser_data};
         if (load_w || backplane_drive_output != bp_q_reg) quiet_reg <= 4'h0;
         else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence s_clk_high;
      ser_clk [*2] ##1 !ser_clk;
   endsequence
   sequence s_first_rise;
      !ser_clk ##[1:3] (ser_clk && ser_data);
   endsequence
   idle_clk_low_a: assert property (!busy |-> !ser_clk)
      else $error("link clock high while idle");
   clk_high_two_a: assert property ($rose(ser_clk) |-> s_clk_high)
      else $error("link clock high phase wrong");
   clk_low_two_a: assert property ($fell(ser_clk) |-> !ser_clk ##1 !ser_clk)
      else $error("link clock low phase short");
   data_setup_a: assert property (ser_clk |-> $stable(ser_data))
      else $error("data moved while link clock high");
   first_rise_a: assert property ($rose(busy) |-> s_first_rise)
      else $error("frame did not open with a one");
   start_bit_a: assert property (rise_w && rise_reg == 6'h0 |-> ser_data)
      else $error("start bit not one");
   filler_zero_a: assert property (rise_w && rise_reg > 6'h21 |-> !ser_data)
      else $error("filler bit not zero");
   frame_whole_a: assert property ($fell(busy) |-> rise_reg == 6'h0)
      else $error("frame ended short of 36 clocks");
   latch_load_a: assert property (load_w |-> ##[3:6] (segment_drive == (shadow_reg ^ {33{backplane_drive_output}})))
      else $error("segments not loaded after 36th rise");
   // a backplane edge moves every segment in the same cycle, so it is excused
   hold_pattern_a: assert property (quiet_reg > 4'h8 && $stable(backplane_drive_output) |-> $stable(segment_drive))
      else $error("segments moved without a load");
endmodule
